// ==== rtl/timer_compare_top.sv ====
// Top of the 16-bit timer compare output stage with normal-mode counting.
// Assumes an APB master on pclk; the pin pad resolves pin_out with pin_oe.
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module timer_compare_top #(
  parameter int unsigned COUNT_W = timer_pkg::COUNT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [timer_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt controller handshake
  input wire logic overflow_ack,
  // Status
  output logic overflow_flag,
  output logic compare_match_flag,
  // Pin
  output logic pin_out,
  output logic pin_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  timer_pkg::ctrl_t ctrl_reg;
  logic port_value_reg;
  logic pin_direction_reg;
  logic [COUNT_W-1:0] counter_reg;
  logic [COUNT_W-1:0] counter_next;
  logic [COUNT_W-1:0] compare_reg;
  logic block_reg;
  logic ovf_reg;
  logic ovf_next;
  logic match_flag_reg;
  logic match_flag_next;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic pin_out_reg;
  logic pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic setup;
  logic wr_en;
  logic wr_ctrl;
  logic wr_port;
  logic wr_count;
  logic wr_compare;
  logic wr_status;
  logic wr_force;
  logic mapped;
  logic [31:0] rd_mux;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite;
  assign wr_ctrl = wr_en && paddr == timer_pkg::CTRL_OFFSET;
  assign wr_port = wr_en && paddr == timer_pkg::PORT_OFFSET;
  assign wr_count = wr_en && paddr == timer_pkg::COUNT_OFFSET;
  assign wr_compare = wr_en && paddr == timer_pkg::COMPARE_OFFSET;
  assign wr_status = wr_en && paddr == timer_pkg::STATUS_OFFSET;
  assign wr_force = wr_en && paddr == timer_pkg::FORCE_OFFSET &&
                    pwdata[timer_pkg::FORCE_BIT];
  assign mapped = paddr == timer_pkg::CTRL_OFFSET || paddr == timer_pkg::PORT_OFFSET ||
                  paddr == timer_pkg::COUNT_OFFSET || paddr == timer_pkg::COMPARE_OFFSET ||
                  paddr == timer_pkg::STATUS_OFFSET || paddr == timer_pkg::FORCE_OFFSET;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      timer_pkg::CTRL_OFFSET: rd_mux[8:0] = ctrl_reg;
      timer_pkg::PORT_OFFSET: begin
        rd_mux[timer_pkg::PORT_VALUE_BIT] = port_value_reg;
        rd_mux[timer_pkg::PORT_DIR_BIT] = pin_direction_reg;
      end
      timer_pkg::COUNT_OFFSET: rd_mux[COUNT_W-1:0] = counter_reg;
      timer_pkg::COMPARE_OFFSET: rd_mux[COUNT_W-1:0] = compare_reg;
      timer_pkg::STATUS_OFFSET: begin
        rd_mux[timer_pkg::STATUS_OVF_BIT] = ovf_reg;
        rd_mux[timer_pkg::STATUS_MATCH_BIT] = match_flag_reg;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data and the error answer are caught in the setup cycle, so the
  // access phase always completes in one cycle with registered outputs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup;
      if (setup) begin
        prdata_reg <= rd_mux;
        pslverr_reg <= !mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= timer_pkg::CTRL_RESET;
      port_value_reg <= 1'b0;
      pin_direction_reg <= 1'b0;
      compare_reg <= timer_pkg::COUNT_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pwdata[8:0];
      end
      if (wr_port) begin
        port_value_reg <= pwdata[timer_pkg::PORT_VALUE_BIT];
        pin_direction_reg <= pwdata[timer_pkg::PORT_DIR_BIT];
      end
      if (wr_compare) begin
        compare_reg <= pwdata[COUNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter and match

  logic tick;
  logic raw_match;
  logic match;
  logic wrap;
  logic oc_state;
  logic pwm;

  timer_prescaler #(
    .DIV_W(10)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clock_sel(ctrl_reg.clock_sel),
    .tick(tick)
  );

  // Counting ignores the compare mode field entirely; every mode counts up
  // and wraps here because the top-limited sequences live outside this block.
  assign counter_next = counter_reg + 1'b1;
  assign raw_match = tick && counter_reg == compare_reg;
  assign match = raw_match && !block_reg;
  assign wrap = tick && !wr_count && counter_next == timer_pkg::COUNT_RESET;
  assign pwm = timer_pkg::is_pwm(ctrl_reg.waveform_mode_field);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_reg <= timer_pkg::COUNT_RESET;
      block_reg <= 1'b0;
    end else begin
      if (wr_count) begin
        counter_reg <= pwdata[COUNT_W-1:0];
      end else if (tick) begin
        counter_reg <= counter_next;
      end
      // The block stays armed, even with the timer stopped, until one tick passes.
      if (wr_count) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a hardware set wins over a same-cycle clear.

  assign ovf_next = wrap ? 1'b1 :
                    (overflow_ack || (wr_status && pwdata[timer_pkg::STATUS_OVF_BIT])) ?
                    1'b0 : ovf_reg;
  assign match_flag_next = match ? 1'b1 :
                           (wr_status && pwdata[timer_pkg::STATUS_MATCH_BIT]) ?
                           1'b0 : match_flag_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
      match_flag_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_next;
      match_flag_reg <= match_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare output and pin override

  // The compare mode goes only to the waveform generator and the pin mux; the
  // capture path never sees it.
  compare_output_unit u_output_unit (
    .pclk(pclk),
    .presetn(presetn),
    .waveform_mode_field(ctrl_reg.waveform_mode_field),
    .compare_output_mode_field(ctrl_reg.compare_output_mode_field),
    .match(match),
    .force_compare_strobe(wr_force),
    .wrap(wrap),
    .compare_output_state(oc_state)
  );

  logic override;

  // Setting 1 is reserved in PWM modes, so the port keeps the pin there.
  assign override = ctrl_reg.compare_output_mode_field != timer_pkg::CMODE_NONE &&
                    !(pwm && ctrl_reg.compare_output_mode_field == timer_pkg::CMODE_TOGGLE);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_out_reg <= override ? oc_state : port_value_reg;
      pin_oe_reg <= pin_direction_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign overflow_flag = ovf_reg;
  assign compare_match_flag = match_flag_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_override_pin_value: assert property (override |=> pin_out == $past(oc_state))
    else $error("Pin does not follow compare output state.");
  a_port_pin_value: assert property (!override |=> pin_out == $past(port_value_reg))
    else $error("Pin does not follow port value.");
  a_pin_direction_gate: assert property (1'b1 |=> pin_oe == $past(pin_direction_reg))
    else $error("Pin enable does not follow direction bit.");
  a_wrap_sets_ovf: assert property (wrap |=> overflow_flag)
    else $error("Overflow flag not set at wrap.");
  a_ack_clears_ovf: assert property (overflow_ack && !wrap |=> !overflow_flag)
    else $error("Overflow flag not cleared by interrupt entry.");
  a_write_blocks_match: assert property (wr_count ##1 (!wr_count && tick)[*1] |-> !match)
    else $error("Match after counter write.");
  a_force_no_flag: assert property (wr_force && !match && !match_flag_reg
                                    |=> !compare_match_flag)
    else $error("Forced compare set the match flag.");
  a_force_keeps_count: assert property (wr_force && !tick |=> $stable(counter_reg))
    else $error("Forced compare changed the counter.");
  a_toggle_on_match: assert property (!pwm && match && !wr_force &&
                                      ctrl_reg.compare_output_mode_field == timer_pkg::CMODE_TOGGLE
                                      |=> oc_state != $past(oc_state))
    else $error("Toggle setting did not toggle.");
  a_none_holds_state: assert property (!pwm && ctrl_reg.compare_output_mode_field ==
                                       timer_pkg::CMODE_NONE |=> $stable(oc_state))
    else $error("Compare mode zero changed the state.");
  a_count_increments: assert property (tick && !wr_count
                                       |=> counter_reg == $past(counter_reg) + 1'b1)
    else $error("Counter did not increment.");

  c_overflow: cover property (wrap ##1 overflow_flag);
  c_force_action: cover property (wr_force ##1 $changed(oc_state));
  c_blocked_match: cover property (raw_match && block_reg);
  c_pin_override: cover property (override && pin_direction_reg ##1 pin_oe);

endmodule

// ==== rtl/timer_pkg.sv ====
// Constants, register map and carrier types for the 16-bit timer compare block.
// Assumes a single 100 MHz APB clock; the timer tick comes from the prescaler.
package timer_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned COUNT_W = 16;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PORT_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  localparam logic [7:0] COMPARE_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] FORCE_OFFSET = 8'h14;

  // Field positions.
  localparam int unsigned CTRL_WAVE_LSB = 0;
  localparam int unsigned CTRL_CMODE_LSB = 4;
  localparam int unsigned CTRL_CSEL_LSB = 6;
  localparam int unsigned PORT_VALUE_BIT = 0;
  localparam int unsigned PORT_DIR_BIT = 1;
  localparam int unsigned STATUS_OVF_BIT = 0;
  localparam int unsigned STATUS_MATCH_BIT = 1;
  localparam int unsigned FORCE_BIT = 0;

  // Compare output mode encodings.
  localparam logic [1:0] CMODE_NONE = 2'h0;
  localparam logic [1:0] CMODE_TOGGLE = 2'h1;
  localparam logic [1:0] CMODE_CLEAR = 2'h2;
  localparam logic [1:0] CMODE_SET = 2'h3;

  // Waveform modes of interest.
  localparam logic [3:0] WAVE_NORMAL = 4'h0;
  localparam logic [3:0] WAVE_CTC_A = 4'h4;
  localparam logic [3:0] WAVE_CTC_B = 4'hC;
  localparam logic [3:0] WAVE_FAST_8 = 4'h5;
  localparam logic [3:0] WAVE_FAST_9 = 4'h6;
  localparam logic [3:0] WAVE_FAST_10 = 4'h7;
  localparam logic [3:0] WAVE_FAST_ICR = 4'hE;
  localparam logic [3:0] WAVE_FAST_OCR = 4'hF;

  // Clock select encodings and divide ratios.
  localparam logic [2:0] CSEL_STOP = 3'h0;
  localparam logic [2:0] CSEL_DIV1 = 3'h1;
  localparam logic [2:0] CSEL_DIV8 = 3'h2;
  localparam logic [2:0] CSEL_DIV64 = 3'h3;
  localparam logic [2:0] CSEL_DIV256 = 3'h4;
  localparam logic [9:0] DIV8_LAST = 10'h007;
  localparam logic [9:0] DIV64_LAST = 10'h03F;
  localparam logic [9:0] DIV256_LAST = 10'h0FF;
  localparam logic [9:0] DIV1024_LAST = 10'h3FF;

  localparam logic [15:0] COUNT_RESET = 16'h0000;

  typedef struct packed {
    logic [2:0] clock_sel;
    logic [1:0] compare_output_mode_field;
    logic [3:0] waveform_mode_field;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{3'h0, 2'h0, 4'h0};

  // True for every waveform mode that generates PWM.
  function automatic logic is_pwm(input logic [3:0] mode);
    return !(mode == WAVE_NORMAL || mode == WAVE_CTC_A || mode == WAVE_CTC_B);
  endfunction

endpackage

// ==== rtl/timer_prescaler.sv ====
// Prescaler that turns the bus clock into one-cycle timer tick enables.
// Assumes clock_sel is static software state; changing it does not restart the divider, only the stop setting clears it.
`timescale 1ns/10ps
module timer_prescaler #(
  parameter int unsigned DIV_W = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic [2:0] clock_sel,
  // Tick
  output logic tick
);

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] last;
  logic wrap;

  assign last = (clock_sel == timer_pkg::CSEL_DIV8) ? timer_pkg::DIV8_LAST :
                (clock_sel == timer_pkg::CSEL_DIV64) ? timer_pkg::DIV64_LAST :
                (clock_sel == timer_pkg::CSEL_DIV256) ? timer_pkg::DIV256_LAST :
                timer_pkg::DIV1024_LAST;
  assign wrap = (div_reg >= last);
  assign tick = (clock_sel == timer_pkg::CSEL_DIV1) ||
                (clock_sel != timer_pkg::CSEL_STOP && wrap);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= '0;
    end else if (clock_sel == timer_pkg::CSEL_STOP || wrap) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

endmodule

// ==== rtl/compare_output_unit.sv ====
// Waveform generator holding the internal compare output state.
// Assumes match, force and wrap are one-cycle pulses; match and wrap are already qualified by the tick.
`timescale 1ns/10ps
module compare_output_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic [3:0] waveform_mode_field,
  input wire logic [1:0] compare_output_mode_field,
  // Events
  input wire logic match,
  input wire logic force_compare_strobe,
  input wire logic wrap,
  // State
  output logic compare_output_state
);

  logic pwm;
  logic state_next;
  logic hit;

  assign pwm = timer_pkg::is_pwm(waveform_mode_field);
  // Forcing acts only outside PWM, exactly like a real match.
  assign hit = match || (!pwm && force_compare_strobe);

  always_comb begin
    state_next = compare_output_state;
    if (!pwm && hit) begin
      unique case (compare_output_mode_field)
        timer_pkg::CMODE_NONE: state_next = compare_output_state;
        timer_pkg::CMODE_TOGGLE: state_next = !compare_output_state;
        timer_pkg::CMODE_CLEAR: state_next = 1'b0;
        timer_pkg::CMODE_SET: state_next = 1'b1;
      endcase
    end else if (pwm && compare_output_mode_field[1]) begin
      // Setting 2 is inverted, 3 non-inverted; setting 1 is reserved and does nothing.
      if (hit) begin
        state_next = !compare_output_mode_field[0];
      end else if (wrap) begin
        state_next = compare_output_mode_field[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_state <= 1'b0;
    end else begin
      compare_output_state <= state_next;
    end
  end

endmodule

// ==== bench/pin_pad_model.sv ====
// Model of the port pin net that the timer top drives through its pad.
// Assumes pin_out and pin_oe come registered from the timer top on pclk.
`timescale 1ns/10ps
module pin_pad_model (
  // Clock
  input wire logic pclk,
  // Driver side
  input wire logic pin_out,
  input wire logic pin_oe,
  // Net
  output logic pin_level
);
  logic float_reg = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // The net has no pull, so an undriven pin wanders instead of keeping its last level.
  always_ff @(posedge pclk) begin
    float_reg <= ~float_reg;
  end

  assign pin_level = pin_oe ? pin_out : float_reg;
endmodule

// ==== bench/test_compare_output_and_normal_mode.sv ====
// Self-checking bench for the timer compare output stage and normal counting.
// Assumes the APB slave answers with pready and that the pad model resolves the pin.
`timescale 1ns/10ps
module test_compare_output_and_normal_mode;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic overflow_ack = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, overflow_flag, compare_match_flag, pin_out, pin_oe, pin_level;
  logic [31:0] r;
  logic e;
  int errors = 0;
  int samples_checked = 0;

  always #5 pclk = ~pclk;

  timer_compare_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overflow_ack(overflow_ack), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_pad_model i_pad (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: no pready", $time);
      conclude();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    chk({31'h0, e}, 32'h0, "write error");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    xfer(1'b0, a, 32'h0);
    chk({31'h0, e}, 32'h0, "read error");
    chk(r, exp, what);
  endtask

  function automatic logic [31:0] ctrl(input logic [2:0] cs, input logic [1:0] cm,
    input logic [3:0] wm);
    return {23'h0, cs, cm, wm};
  endfunction

  // A flag that never rises within the bound counts as a mismatch and ends the run.
  task automatic wait_for(input logic on_match);
    int n;
    n = 0;
    while ((on_match ? compare_match_flag : overflow_flag) !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if ((on_match ? compare_match_flag : overflow_flag) !== 1'b1) begin
      errors++;
      $display("unexpected at %0t: flag never rose", $time);
      conclude();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(timer_pkg::CTRL_OFFSET, 32'h0, "ctrl reset");
    rd(timer_pkg::COUNT_OFFSET, 32'h0, "count reset");
    rd(timer_pkg::STATUS_OFFSET, 32'h0, "status reset");
    wr(timer_pkg::PORT_OFFSET, 32'h3);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, timer_pkg::CMODE_TOGGLE, 4'h0));
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h0, "state after reset");
    xfer(1'b0, 8'h20, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_force();
    logic [1:0] cm [5];
    logic ex [5];
    cm = '{timer_pkg::CMODE_CLEAR, timer_pkg::CMODE_TOGGLE, timer_pkg::CMODE_TOGGLE,
      timer_pkg::CMODE_SET, timer_pkg::CMODE_NONE};
    ex = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    wr(timer_pkg::PORT_OFFSET, 32'h0);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, timer_pkg::CMODE_SET, 4'h0));
    wr(timer_pkg::FORCE_OFFSET, 32'h1);
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_oe}, 32'h0, "pin driven while input");
    wr(timer_pkg::PORT_OFFSET, 32'h2);
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h1, "preset state on pin");
    chk({31'h0, compare_match_flag}, 32'h0, "flag after force");
    rd(timer_pkg::COUNT_OFFSET, 32'h0, "count after force");
    for (int i = 0; i < 5; i++) begin
      wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, cm[i], 4'h0));
      wr(timer_pkg::FORCE_OFFSET, 32'h1);
      repeat (4) @(posedge pclk);
      chk({31'h0, pin_level}, {31'h0, ex[i]}, "forced action");
    end
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, timer_pkg::CMODE_TOGGLE, 4'h0));
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h1, "state kept by mode zero");
    $display("test force done");
  endtask

  task automatic t_wrap();
    wr(timer_pkg::COMPARE_OFFSET, 32'h0000FFFE);
    wr(timer_pkg::COUNT_OFFSET, 32'h0000FFFD);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_DIV1, timer_pkg::CMODE_TOGGLE, 4'h0));
    wait_for(1'b0);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, timer_pkg::CMODE_TOGGLE, 4'h0));
    xfer(1'b0, timer_pkg::COUNT_OFFSET, 32'h0);
    chk(r & 32'hFF00, 32'h0, "count wrapped");
    chk({31'h0, overflow_flag}, 32'h1, "overflow sticky");
    chk({31'h0, compare_match_flag}, 32'h1, "match flag");
    chk({31'h0, pin_level}, 32'h0, "toggle on match");
    overflow_ack <= 1'b1;
    @(posedge pclk);
    overflow_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({31'h0, overflow_flag}, 32'h0, "overflow ack");
    wr(timer_pkg::STATUS_OFFSET, 32'h2);
    rd(timer_pkg::STATUS_OFFSET, 32'h0, "status cleared");
    $display("test wrap done");
  endtask

  task automatic t_block();
    wr(timer_pkg::COMPARE_OFFSET, 32'h00000010);
    wr(timer_pkg::COUNT_OFFSET, 32'h00000010);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_DIV8, timer_pkg::CMODE_TOGGLE, 4'h0));
    repeat (24) @(posedge pclk);
    wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, timer_pkg::CMODE_TOGGLE, 4'h0));
    repeat (3) @(posedge pclk);
    chk({31'h0, compare_match_flag}, 32'h0, "blocked match");
    chk({31'h0, pin_level}, 32'h0, "state after block");
    xfer(1'b0, timer_pkg::COUNT_OFFSET, 32'h0);
    chk(r & 32'hFFF0, 32'h10, "count moved on");
    $display("test block done");
  endtask

  task automatic t_pwm();
    wr(timer_pkg::CTRL_OFFSET, ctrl(3'h0, timer_pkg::CMODE_SET, timer_pkg::WAVE_FAST_8));
    wr(timer_pkg::FORCE_OFFSET, 32'h1);
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h0, "force ignored in pwm");
    wr(timer_pkg::PORT_OFFSET, 32'h3);
    wr(timer_pkg::CTRL_OFFSET, ctrl(3'h0, timer_pkg::CMODE_TOGGLE, timer_pkg::WAVE_FAST_8));
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h1, "reserved setting");
    wr(timer_pkg::CTRL_OFFSET, ctrl(3'h0, timer_pkg::CMODE_CLEAR, timer_pkg::WAVE_FAST_8));
    repeat (4) @(posedge pclk);
    chk({31'h0, pin_level}, 32'h0, "override in pwm");
    $display("test pwm done");
  endtask

  // Setting 2 sets at match and clears at wrap; setting 3 does the opposite.
  task automatic t_pwm_run();
    logic [1:0] cm [2];
    logic lm [2];
    logic lw [2];
    cm = '{timer_pkg::CMODE_CLEAR, timer_pkg::CMODE_SET};
    lm = '{1'b1, 1'b0};
    lw = '{1'b0, 1'b1};
    wr(timer_pkg::COMPARE_OFFSET, 32'h0000FFF2);
    for (int i = 0; i < 2; i++) begin
      wr(timer_pkg::STATUS_OFFSET, 32'h3);
      wr(timer_pkg::COUNT_OFFSET, 32'h0000FFF0);
      wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_DIV1, cm[i], timer_pkg::WAVE_FAST_8));
      wait_for(1'b1);
      wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, cm[i], timer_pkg::WAVE_FAST_8));
      chk({31'h0, pin_level}, {31'h0, lm[i]}, "pwm level after match");
      wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_DIV1, cm[i], timer_pkg::WAVE_FAST_8));
      wait_for(1'b0);
      wr(timer_pkg::CTRL_OFFSET, ctrl(timer_pkg::CSEL_STOP, cm[i], timer_pkg::WAVE_FAST_8));
      chk({31'h0, pin_level}, {31'h0, lw[i]}, "pwm level after wrap");
    end
    $display("test pwm run done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_force();
    t_wrap();
    t_block();
    t_pwm();
    t_pwm_run();
    conclude();
  end
endmodule
